// *** logic/carrier_word_channel_regs.sv ***
`timescale 1ns/1ns
// Functional notes
// - Hold a read/write 8-bit node id used by the receive address filter.
// - Channel index times channel spacing is added to the base carrier.
// - A 5-bit IF code sets the IF in steps of crystal over 2^10.
// - In receive the IF is subtracted and the code also drives the mixer.
// - A signed 8-bit trim in steps of crystal over 2^14 adds to the base.
// - Carrier word bits 23:22 are read-only and always read as zero.
// - Three byte registers form the 24-bit carrier word, step 2^-16.
// - 2-bit bandwidth exponent and mantissa set decimation 8*(4+M)*2^E.
// - The low nibble of the bandwidth register holds the rate exponent.
// - Symbol rate uses a 9-bit mantissa with hidden one and 4-bit exponent.
// - A 2-bit filter mode picks none, exact, +0x00 or +0x00/0xFF match.
module carrier_word_channel_regs
  import carrier_word_cfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe,
  input  wire logic        rx_mode,
  input  wire logic [15:0] rf_slot_number_spacing,
  input  wire logic [1:0]  node_filter_mode,
  input  wire logic [7:0]  rx_addr_byte,
  input  wire logic [7:0]  symbol_rate_mantissa,
  output logic [7:0]       node_filter_id,
  output logic             addr_match,
  output logic [7:0]       rf_slot_number,
  output logic [4:0]       intermediate_offset_code,
  output logic [7:0]       synth_trim_offset,
  output logic [23:0]      carrier_word,
  output logic [23:0]      synth_word,
  output logic [1:0]       filter_bw_exponent,
  output logic [1:0]       filter_bw_mantissa,
  output logic [8:0]       decim_ratio,
  output logic [3:0]       symbol_rate_exponent,
  output logic [8:0]       rate_mantissa_full
);

  typedef struct packed {
    access_st_e  st;
    logic [5:0]  addr;
    logic        rd;
    logic        burst;
    logic [7:0]  node_id;
    logic [7:0]  slot;
    logic [4:0]  if_code;
    logic [7:0]  trim;
    logic [5:0]  cw_high;
    logic [7:0]  cw_mid;
    logic [7:0]  cw_low;
    logic [1:0]  bw_exp;
    logic [1:0]  bw_mant;
    logic [3:0]  rate_exp;
    logic [23:0] synth;
    logic [8:0]  decim;
    logic        match;
    logic [8:0]  rate_mant;
  } regs_s;

  spi_byte_if link_bus ();

  regs_s       r;
  regs_s       n;
  logic [7:0]  hdr;
  logic [23:0] cw_full;
  logic [23:0] slot_term;
  logic [23:0] trim_term;
  logic [23:0] if_term;
  logic        id_eq;

  // ************************************************************
  // Serial byte link
  // ************************************************************
  spi_byte_link u_link (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sclk    (sclk),
    .cs_n    (cs_n),
    .si      (si),
    .so      (so),
    .so_oe   (so_oe),
    .bus     (link_bus.link)
  );

  // ************************************************************
  // Read data selection
  // ************************************************************
  function automatic logic [7:0] read_mux(input regs_s s,
                                          input logic [5:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == OFF_NODE_ID) begin
      d = s.node_id;
    end else if (a == OFF_SLOT) begin
      d = s.slot;
    end else if (a == OFF_IF_CTL) begin
      d = {3'h0, s.if_code};
    end else if (a == OFF_TRIM) begin
      d = s.trim;
    end else if (a == OFF_CW_HIGH) begin
      d = {2'h0, s.cw_high};
    end else if (a == OFF_CW_MID) begin
      d = s.cw_mid;
    end else if (a == OFF_CW_LOW) begin
      d = s.cw_low;
    end else if (a == OFF_BW_RATE) begin
      d = {s.bw_exp, s.bw_mant, s.rate_exp};
    end
    return d;
  endfunction : read_mux

  // Reply byte: status during the header and writes, register data after a read header
  always_comb begin
    if (r.st == ST_DATA && r.rd) begin
      link_bus.tx_byte = read_mux(r, r.addr);
    end else begin
      link_bus.tx_byte = STATUS_BYTE;
    end
  end

  // ************************************************************
  // Access sequencer and register writes
  // ************************************************************
  always_comb begin
    hdr = link_bus.rx_byte;
    n   = r;
    if (!link_bus.frame_on) begin
      n.st = ST_HEADER;
    end else if (link_bus.byte_valid) begin
      case (r.st)
        ST_HEADER: begin
          n.addr  = hdr[5:0];
          n.rd    = hdr[HDR_READ_BIT];
          n.burst = hdr[HDR_BURST_BIT];
          n.st    = ST_DATA;
        end
        ST_DATA: begin
          if (!r.rd) begin
            if (r.addr == OFF_NODE_ID) begin
              n.node_id = hdr;
            end else if (r.addr == OFF_SLOT) begin
              n.slot = hdr;
            end else if (r.addr == OFF_IF_CTL) begin
              n.if_code = hdr[IF_CODE_MSB:0];
            end else if (r.addr == OFF_TRIM) begin
              n.trim = hdr;
            end else if (r.addr == OFF_CW_HIGH) begin
              n.cw_high = hdr[CW_HIGH_MSB:0];
            end else if (r.addr == OFF_CW_MID) begin
              n.cw_mid = hdr;
            end else if (r.addr == OFF_CW_LOW) begin
              n.cw_low = hdr;
            end else if (r.addr == OFF_BW_RATE) begin
              n.bw_exp   = hdr[BW_EXP_LSB +: 2];
              n.bw_mant  = hdr[BW_MANT_LSB +: 2];
              n.rate_exp = hdr[3:0];
            end
          end
          if (r.burst) begin
            n.addr = r.addr + 6'h01;
          end else begin
            n.st = ST_HEADER;
          end
        end
        default: begin
          n.st = ST_HEADER;
        end
      endcase
    end

    // Synthesizer word in carrier units
    cw_full   = {2'h0, r.cw_high, r.cw_mid, r.cw_low};
    slot_term = {16'h0, r.slot} * {8'h0, rf_slot_number_spacing};
    trim_term = 24'({{16{r.trim[7]}}, r.trim}
                    << TRIM_TO_CW_SHIFT);
    if_term   = 24'({19'h0, r.if_code} << IF_TO_CW_SHIFT);
    n.synth   = cw_full + slot_term + trim_term
                - (rx_mode ? if_term : 24'h0);

    // Channel filter decimation ratio
    n.decim = 9'((BW_DECIM_UNIT * (BW_MANT_BASE + {7'h0, r.bw_mant}))
                 << r.bw_exp);

    // Symbol rate mantissa with hidden leading one
    n.rate_mant = {1'b1, symbol_rate_mantissa};

    // Receive address filter
    id_eq = (rx_addr_byte == r.node_id);
    case (node_filter_mode)
      FILT_NONE:    n.match = 1'b1;
      FILT_EXACT:   n.match = id_eq;
      FILT_BC_ZERO: n.match = id_eq
                              | (rx_addr_byte == BCAST_ZERO);
      default:      n.match = id_eq | (rx_addr_byte == BCAST_ZERO)
                              | (rx_addr_byte == BCAST_ONES);
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{st: ST_HEADER, addr: 6'h00, rd: 1'b0, burst: 1'b0,
             node_id: RST_NODE_ID, slot: RST_SLOT, if_code: RST_IF_CODE,
             trim: RST_TRIM, cw_high: RST_CW_HIGH, cw_mid: RST_CW_MID,
             cw_low: RST_CW_LOW, bw_exp: RST_BW_EXP,
             bw_mant: RST_BW_MANT, rate_exp: RST_RATE_EXP,
             synth: 24'h000000, decim: 9'h000, match: 1'b0,
             rate_mant: 9'h100};
    end else begin
      r <= n;
    end
  end

  // ************************************************************
  // Configuration outputs
  // ************************************************************
  assign node_filter_id           = r.node_id;
  assign addr_match               = r.match;
  assign rf_slot_number           = r.slot;
  assign intermediate_offset_code = r.if_code;
  assign synth_trim_offset        = r.trim;
  assign carrier_word             = {2'h0, r.cw_high, r.cw_mid, r.cw_low};
  assign synth_word               = r.synth;
  assign filter_bw_exponent       = r.bw_exp;
  assign filter_bw_mantissa       = r.bw_mant;
  assign decim_ratio              = r.decim;
  assign symbol_rate_exponent     = r.rate_exp;
  assign rate_mantissa_full       = r.rate_mant;

endmodule : carrier_word_channel_regs

// *** logic/carrier_word_cfg_pkg.sv ***
package carrier_word_cfg_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [5:0] OFF_NODE_ID   = 6'h09;
  localparam logic [5:0] OFF_SLOT      = 6'h0A;
  localparam logic [5:0] OFF_IF_CTL    = 6'h0B;
  localparam logic [5:0] OFF_TRIM      = 6'h0C;
  localparam logic [5:0] OFF_CW_HIGH   = 6'h0D;
  localparam logic [5:0] OFF_CW_MID    = 6'h0E;
  localparam logic [5:0] OFF_CW_LOW    = 6'h0F;
  localparam logic [5:0] OFF_BW_RATE   = 6'h10;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_NODE_ID   = 8'h00;
  localparam logic [7:0] RST_SLOT      = 8'h00;
  localparam logic [4:0] RST_IF_CODE   = 5'h0F;
  localparam logic [7:0] RST_TRIM      = 8'h00;
  localparam logic [5:0] RST_CW_HIGH   = 6'h1E;
  localparam logic [7:0] RST_CW_MID    = 8'hC4;
  localparam logic [7:0] RST_CW_LOW    = 8'hEC;
  localparam logic [1:0] RST_BW_EXP    = 2'h2;
  localparam logic [1:0] RST_BW_MANT   = 2'h0;
  localparam logic [3:0] RST_RATE_EXP  = 4'hC;

  // ************************************************************
  // Field positions and access header layout
  // ************************************************************
  localparam int HDR_READ_BIT   = 7;
  localparam int HDR_BURST_BIT  = 6;
  localparam int BW_EXP_LSB     = 6;
  localparam int BW_MANT_LSB    = 4;
  localparam int IF_CODE_MSB    = 4;
  localparam int CW_HIGH_MSB    = 5;
  localparam logic [7:0] STATUS_BYTE = 8'h00;

  // Scaling of IF and trim steps into carrier-word units, and decimation constants
  localparam int IF_TO_CW_SHIFT   = 6;
  localparam int TRIM_TO_CW_SHIFT = 2;
  localparam logic [8:0] BW_DECIM_UNIT = 9'h008;
  localparam logic [8:0] BW_MANT_BASE  = 9'h004;

  // Node filter modes
  localparam logic [1:0] FILT_NONE     = 2'h0;
  localparam logic [1:0] FILT_EXACT    = 2'h1;
  localparam logic [1:0] FILT_BC_ZERO  = 2'h2;
  localparam logic [1:0] FILT_BC_BOTH  = 2'h3;
  localparam logic [7:0] BCAST_ZERO    = 8'h00;
  localparam logic [7:0] BCAST_ONES    = 8'hFF;

  // Access sequencer states
  typedef enum logic [1:0] {
    ST_HEADER = 2'b00,
    ST_DATA   = 2'b01
  } access_st_e;

endpackage : carrier_word_cfg_pkg

// *** logic/spi_byte_if.sv ***
`timescale 1ns/1ns
interface spi_byte_if;
  logic       byte_valid;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic       frame_on;

  modport link (output byte_valid, output rx_byte, output frame_on,
                input tx_byte);
  modport regs (input byte_valid, input rx_byte, input frame_on,
                output tx_byte);
endinterface : spi_byte_if

// *** logic/spi_byte_link.sv ***
`timescale 1ns/1ns
module spi_byte_link (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic si,
  output logic      so,
  output logic      so_oe,
  spi_byte_if.link  bus
);

  typedef struct packed {
    logic [1:0] sclk_q;
    logic [1:0] csn_q;
    logic [1:0] si_q;
    logic       sclk_d;
    logic       csn_d;
    logic [2:0] bit_cnt;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic       byte_valid;
  } link_s;

  link_s r;
  link_s n;
  logic  rise;
  logic  fall;
  logic  active;
  logic  start;

  // ************************************************************
  // Pin synchronisers, edge detection and byte shifting
  // ************************************************************
  always_comb begin
    rise         = r.sclk_q[1] & ~r.sclk_d;
    fall         = ~r.sclk_q[1] & r.sclk_d;
    active       = ~r.csn_q[1];
    start        = active & r.csn_d;
    n            = r;
    n.sclk_q     = {r.sclk_q[0], sclk};
    n.csn_q      = {r.csn_q[0], cs_n};
    n.si_q       = {r.si_q[0], si};
    n.sclk_d     = r.sclk_q[1];
    n.csn_d      = r.csn_q[1];
    n.byte_valid = 1'b0;
    if (!active) begin
      n.bit_cnt = 3'h0;
    end else if (start) begin
      n.bit_cnt = 3'h0;
      n.sh_out  = bus.tx_byte;
    end else if (rise) begin
      n.sh_in   = {r.sh_in[6:0], r.si_q[1]};
      n.bit_cnt = r.bit_cnt + 3'h1;
      if (r.bit_cnt == 3'h7) begin
        n.byte_valid = 1'b1;
      end
    end else if (fall) begin
      // Byte boundary reloads the next reply byte
      if (r.bit_cnt == 3'h0) begin
        n.sh_out = bus.tx_byte;
      end else begin
        n.sh_out = {r.sh_out[6:0], 1'b0};
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{sclk_q: 2'h0, csn_q: 2'h3, si_q: 2'h0, sclk_d: 1'b0,
             csn_d: 1'b1, bit_cnt: 3'h0, sh_in: 8'h00, sh_out: 8'h00,
             byte_valid: 1'b0};
    end else begin
      r <= n;
    end
  end

  // Outputs
  assign so             = r.sh_out[7];
  assign so_oe          = ~r.csn_q[1];
  assign bus.byte_valid = r.byte_valid;
  assign bus.rx_byte    = r.sh_in;
  assign bus.frame_on   = ~r.csn_q[1];

endmodule : spi_byte_link

// *** testbench/spi_host_model.sv ***
`timescale 1ns/1ns
// ************************************************************
// Host side of the serial port, mode 0, MSB first
// ************************************************************
module spi_host_model #(
  parameter int HALF_NS = 200
) (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  // Idle bus, clock stands low outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // Select, then wait before the first rising edge
  task automatic start_frame();
    cs_n = 1'b0;
    #(HALF_NS);
  endtask : start_frame

  // One byte each way, reply sampled on the rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      #(HALF_NS);
      sclk = 1'b1;
      rx[i] = so;
      #(HALF_NS);
      sclk = 1'b0;
    end
  endtask : xfer

  // Deselect; data line flips so no stale bit lingers
  task automatic end_frame();
    #(HALF_NS);
    cs_n = 1'b1;
    si = ~si;
    #(HALF_NS);
  endtask : end_frame
endmodule : spi_host_model

// *** testbench/carrier_word_channel_regs_monitor.sv ***
`timescale 1ns/1ns
module carrier_word_channel_regs_monitor
  import carrier_word_cfg_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        cs_n,
  input wire logic        so_oe,
  input wire logic        rx_mode,
  input wire logic [15:0] rf_slot_number_spacing,
  input wire logic [1:0]  node_filter_mode,
  input wire logic [7:0]  rx_addr_byte,
  input wire logic [7:0]  symbol_rate_mantissa,
  input wire logic [7:0]  node_filter_id,
  input wire logic        addr_match,
  input wire logic [7:0]  rf_slot_number,
  input wire logic [4:0]  intermediate_offset_code,
  input wire logic [7:0]  synth_trim_offset,
  input wire logic [23:0] carrier_word,
  input wire logic [23:0] synth_word,
  input wire logic [1:0]  filter_bw_exponent,
  input wire logic [1:0]  filter_bw_mantissa,
  input wire logic [8:0]  decim_ratio,
  input wire logic [8:0]  rate_mantissa_full
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Host has left the device deselected for a while
  sequence frame_idle;
    cs_n [*6];
  endsequence

  cw_top_zero_a: assert property (
    carrier_word[23:22] == 2'b00) else $error("carrier top bits set");
  synth_sum_a: assert property (
    !$past(sys_rst) |-> synth_word == $past(carrier_word)
      + 24'($past(rf_slot_number)) * 24'($past(rf_slot_number_spacing))
      + {{14{$past(synth_trim_offset[7])}}, $past(synth_trim_offset), 2'b00}
      - ($past(rx_mode) ? 24'($past(intermediate_offset_code)) << 6 : 24'h0)
  ) else $error("synth word sum wrong");
  decim_calc_a: assert property (
    !$past(sys_rst) |-> decim_ratio
      == 9'((9'h020 + 9'h008 * $past(filter_bw_mantissa))
      << $past(filter_bw_exponent))) else $error("decimation wrong");
  rate_full_a: assert property (
    !$past(sys_rst) |->
      rate_mantissa_full == {1'b1, $past(symbol_rate_mantissa)}
  ) else $error("rate mantissa wrong");
  node_match_a: assert property (
    !$past(sys_rst) |-> addr_match == ($past(node_filter_mode) == FILT_NONE
      || $past(rx_addr_byte) == $past(node_filter_id)
      || ($past(node_filter_mode[1]) && $past(rx_addr_byte) == BCAST_ZERO)
      || ($past(node_filter_mode) == FILT_BC_BOTH
          && $past(rx_addr_byte) == BCAST_ONES))) else $error("match wrong");
  idle_drive_a: assert property (
    frame_idle |-> !so_oe) else $error("output driven while idle");
  oe_start_a: assert property (
    $rose(so_oe) |-> !cs_n) else $error("drive without select");
  cfg_hold_a: assert property (
    frame_idle |-> $stable(carrier_word) && $stable(rf_slot_number)
      && $stable(node_filter_id)) else $error("config changed while idle");
endmodule : carrier_word_channel_regs_monitor

bind carrier_word_channel_regs carrier_word_channel_regs_monitor u_mon (.*);

// *** testbench/carrier_word_channel_regs_tb.sv ***
`timescale 1ns/1ns
module carrier_word_channel_regs_tb
  import carrier_word_cfg_pkg::*;
;
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } row_s;
  // ************************************************************
  // Stimulus, wiring and bookkeeping
  // ************************************************************
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        sclk, cs_n, si, so, so_oe, addr_match;
  logic        rx_mode = 1'b0;
  logic [15:0] rf_slot_number_spacing = 16'h0000;
  logic [1:0]  node_filter_mode = 2'h0;
  logic [7:0]  rx_addr_byte = 8'h00;
  logic [7:0]  symbol_rate_mantissa = 8'h00;
  logic [7:0]  node_filter_id, rf_slot_number, synth_trim_offset;
  logic [4:0]  intermediate_offset_code;
  logic [23:0] carrier_word, synth_word;
  logic [1:0]  filter_bw_exponent, filter_bw_mantissa;
  logic [8:0]  decim_ratio, rate_mantissa_full;
  logic [3:0]  symbol_rate_exponent;
  int          error_cnt = 0;
  int          checks = 0;
  int          cycles = 0;
  logic [7:0]  rst_vals [8] = '{8'h00, 8'h00, 8'h0F, 8'h00, 8'h1E, 8'hC4,
                                8'hEC, 8'h8C};
  logic [7:0]  probe [4] = '{8'hA5, 8'h00, 8'hFF, 8'h3C};
  row_s        rows [9] = '{'{6'h09, 8'hA5, 8'hA5}, '{6'h0A, 8'h05, 8'h05},
    '{6'h0B, 8'hFF, 8'h1F}, '{6'h0C, 8'h80, 8'h80}, '{6'h0D, 8'hFF, 8'h3F},
    '{6'h0E, 8'h12, 8'h12}, '{6'h0F, 8'h34, 8'h34}, '{6'h10, 8'h5B, 8'h5B},
    '{6'h20, 8'h55, 8'h00}};

  carrier_word_channel_regs u_carrier_word_channel_regs (.clk(clk), .sys_rst(sys_rst),
    .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .rx_mode(rx_mode), .rf_slot_number_spacing(rf_slot_number_spacing),
    .node_filter_mode(node_filter_mode), .rx_addr_byte(rx_addr_byte),
    .symbol_rate_mantissa(symbol_rate_mantissa),
    .node_filter_id(node_filter_id), .addr_match(addr_match),
    .rf_slot_number(rf_slot_number),
    .intermediate_offset_code(intermediate_offset_code),
    .synth_trim_offset(synth_trim_offset), .carrier_word(carrier_word),
    .synth_word(synth_word), .filter_bw_exponent(filter_bw_exponent),
    .filter_bw_mantissa(filter_bw_mantissa), .decim_ratio(decim_ratio),
    .symbol_rate_exponent(symbol_rate_exponent),
    .rate_mantissa_full(rate_mantissa_full));
  spi_host_model u_spi_host_model (.sclk(sclk), .cs_n(cs_n), .si(si),
    .so(so));

  // Clock at 25 MHz and a cycle ceiling against hangs
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      summarize();
    end
  end

  // Comparisons and register access
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t reg %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t out %h exp %h", $time, got, exp);
    end
  endtask : chk_out
  task automatic xfer_pair(input logic [7:0] h, input logic [7:0] d,
                           output logic [7:0] r);
    logic [7:0] s;
    u_spi_host_model.start_frame();
    u_spi_host_model.xfer(h, s);
    chk_reg(s, STATUS_BYTE);
    u_spi_host_model.xfer(d, r);
    u_spi_host_model.end_frame();
  endtask : xfer_pair
  task automatic summarize();
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    logic [7:0]  r;
    logic [23:0] e;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk_out(24'(decim_ratio), 24'h000080);
    chk_out(24'(rate_mantissa_full), 24'h000100);
    u_spi_host_model.start_frame();
    u_spi_host_model.xfer(8'hC9, r);
    for (int i = 0; i < 8; i++) begin
      u_spi_host_model.xfer(8'h00, r);
      chk_reg(r, rst_vals[i]);
    end
    u_spi_host_model.end_frame();
    foreach (rows[i]) begin
      xfer_pair({2'b00, rows[i].addr}, rows[i].wdata, r);
      xfer_pair({2'b10, rows[i].addr}, 8'h00, r);
      chk_reg(r, rows[i].rdata);
    end
    chk_out(carrier_word, 24'h3F1234);
    chk_out(24'(decim_ratio), 24'h000050);
    chk_out(24'(symbol_rate_exponent), 24'h00000B);
    chk_out(24'({filter_bw_exponent, filter_bw_mantissa}), 24'h000005);
    chk_out(24'({node_filter_id, rf_slot_number, synth_trim_offset}),
            24'hA50580);
    chk_out(24'(intermediate_offset_code), 24'h00001F);
    @(posedge clk);
    #1 rx_mode = 1'b1;
    rf_slot_number_spacing = 16'h0123;
    symbol_rate_mantissa = 8'h22;
    repeat (2) @(posedge clk);
    #1 e = 24'h3F1234 + 24'h5 * 24'h123 - 24'h200 - 24'h7C0;
    chk_out(synth_word, e);
    chk_out(24'(rate_mantissa_full), 24'h000122);
    @(posedge clk);
    #1 rx_mode = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk_out(synth_word, e + 24'h7C0);
    for (int m = 0; m < 4; m++) begin
      foreach (probe[k]) begin
        @(posedge clk);
        #1 node_filter_mode = 2'(m);
        rx_addr_byte = probe[k];
        repeat (2) @(posedge clk);
        #1 chk_out(24'(addr_match), 24'(m == 0 || probe[k] == 8'hA5
          || (m > 1 && probe[k] == 8'h00) || (m == 3 && probe[k] == 8'hFF)));
      end
    end
    // Mid-run reset brings back reset values and the derived word
    @(posedge clk);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk_out(carrier_word, 24'h1EC4EC);
    chk_out(24'({node_filter_id, rf_slot_number, synth_trim_offset}),
            24'h000000);
    sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk_out(synth_word, 24'h1EC4EC);
    chk_out(24'(intermediate_offset_code), 24'h00000F);
    summarize();
  end
endmodule : carrier_word_channel_regs_tb
